// file: hw/ims_sequencer.sv
// Purpose: I2C master sequencer: START, repeated START, byte transmit,
//          byte receive and acknowledge, paced by the rate counter.
// Assumes: Software strobes are single-cycle pulses on clk; pins are
//          open-drain, oe high pulls the line low.
// Notes:   STOP, slave mode and data-phase arbitration are not handled.
// How it works
// - Start request with both lines high loads counter; lines still high at timeout pull SDA.
// - SDA falling while SCL high is START; start-detected status is set.
// - After START one more period, then start bit clears, counter stops, SDA held.
// - Lines low at start, or SCL low before SDA falls, flags bus collision.
// - Buffer write during START is dropped and sets write collision.
// - Control writes to the low five bits are ignored until START completes.
// - Restart pulls SCL low, then loads low six reload bits, releases SDA one period.
// - Timeout with SDA high releases SCL; both high a period; then SDA low a period.
// - SDA low sets start-detected; after the next timeout the restart bit clears and interrupt is set.
// - Restart request while another event runs is ignored.
// - SDA low as SCL rises, or SCL falling early, flags bus collision in restart.
// - Buffer writes dropped and control writes blocked during restart.
// - Buffer write in idle sets buffer full and starts the counter.
// - Each bit: data changes in the same cycle SCL is pulled low, SCL low one period, high one period.
// - Eighth falling edge clears buffer full and releases SDA for acknowledge.
// - Ninth falling edge samples SDA into acknowledge status, low means acknowledged.
// - After ninth clock interrupt flag is set and SCL held low until next write.
// - Buffer writes while shifting set write collision, cleared only by software.
// - Receive toggles SCL per period; eighth fall stores byte, sets flags, idles low.
// - Reading the buffer in idle clears buffer full.
// - A byte completing while buffer full sets receive overflow.
// - Acknowledge sequence drives the value bit for one clock, clears enable, idles.
// - A released SCL pauses the counter until SCL is sampled high.
// - Counter counts down from the reload value to zero, twice per instruction cycle.
`timescale 1ns/1ps
module ims_sequencer
  import ims_pkg::*;
#(
  parameter int DIV = CLKS_PER_DEC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Second control register writes
  input  wire logic                  ctrlWrite,
  input  wire logic [CTRL_LOW_W-1:0] ctrlWriteData,
  input  wire logic                  ackValueBit,
  input  wire logic [RELOAD_W-1:0]   rateReloadField,
  // Data buffer access
  input  wire logic                  bufWrite,
  input  wire logic [DATA_W-1:0]     bufWriteData,
  input  wire logic                  bufRead,
  // Software flag clears
  input  wire logic                  clearWriteCollision,
  input  wire logic                  clearOverflow,
  input  wire logic                  clearBusCollision,
  input  wire logic                  clearPortInterrupt,
  input  wire logic                  clearStartDetected,
  // Status
  output logic                       startRequestBit,
  output logic                       restartRequestBit,
  output logic                       receiveRequestBit,
  output logic                       ackSequenceRequestBit,
  output logic                       ackReceivedStatus,
  output logic                       bufferFullFlag,
  output logic                       writeCollisionFlag,
  output logic                       receiveOverflowFlag,
  output logic                       portInterruptFlag,
  output logic                       busCollisionFlag,
  output logic                       startDetected,
  output logic [DATA_W-1:0]          dataBuffer,
  // Bus pins
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  input  wire logic                  sclIn,
  output logic                       sclOut,
  output logic                       sclOe
);

  typedef enum logic [3:0] {
    S_IDLE, S_ST_WAIT, S_ST_HOLD,
    S_RS_SCLLOW, S_RS_SDAHI, S_RS_SCLREL, S_RS_BOTHHI, S_RS_SDALOW,
    S_BIT_LOW, S_BIT_REL, S_BIT_HIGH
  } ims_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sdaSync_reg;
  logic [1:0] sclSync_reg;
  logic       sdaS;
  logic       sclS;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdaSync_reg <= 2'h3;
      sclSync_reg <= 2'h3;
    end else begin
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclSync_reg <= {sclSync_reg[0], sclIn};
    end
  end

  assign sdaS = sdaSync_reg[1];
  assign sclS = sclSync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  ims_state_t           state_reg,  state_next;
  ims_mode_t            mode_reg,   mode_next;
  logic [BITCNT_W-1:0]  bitCnt_reg, bitCnt_next;
  logic [DATA_W-1:0]    shift_reg,  shift_next;
  logic [DATA_W-1:0]    buf_reg,    buf_next;
  logic [CTRL_LOW_W-1:0] req_reg,   req_next;
  logic                 sdaLow_reg, sdaLow_next;
  logic                 sclLow_reg, sclLow_next;
  logic                 ack_received_status_reg, ack_received_status_next;
  logic                 bf_reg,     bf_next;
  logic                 write_collision_flag_reg,   write_collision_flag_next;
  logic                 ovf_reg,    ovf_next;
  logic                 pif_reg,    pif_next;
  logic                 bcl_reg,    bcl_next;
  logic                 sdet_reg,   sdet_next;
  logic                 load;
  logic                 loadShort;
  logic                 run;
  logic                 timeout;
  logic                 byteDone;
  logic                 rxDone;
  logic [RELOAD_W-1:0]  reloadSel;

  // Short reload is used only by the restart's first period
  assign reloadSel = loadShort ? {1'b0, rateReloadField[RS_RELOAD_W-1:0]}
                               : rateReloadField;
  // Counter pauses while waiting on pin levels
  assign run = !(state_reg inside {S_IDLE, S_RS_SCLLOW, S_RS_SCLREL, S_BIT_REL});

  ims_rate_counter #(
    .RW  (RELOAD_W),
    .DIV (DIV)
  ) u_rate (
    .clk       (clk),
    .reset     (reset),
    .load      (load),
    .run       (run),
    .reloadVal (reloadSel),
    .timeout   (timeout)
  );

  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    bitCnt_next  = bitCnt_reg;
    shift_next   = shift_reg;
    buf_next     = buf_reg;
    req_next     = req_reg;
    sdaLow_next  = sdaLow_reg;
    sclLow_next  = sclLow_reg;
    ack_received_status_next = ack_received_status_reg;
    bf_next      = bf_reg;
    ovf_next     = ovf_reg && !clearOverflow;
    pif_next     = pif_reg && !clearPortInterrupt;
    bcl_next     = bcl_reg && !clearBusCollision;
    sdet_next    = sdet_reg && !clearStartDetected;
    write_collision_flag_next    = write_collision_flag_reg && !clearWriteCollision;
    load         = 1'b0;
    loadShort    = 1'b0;
    byteDone     = 1'b0;
    rxDone       = 1'b0;

    if (bufRead && state_reg == S_IDLE) begin
      bf_next = 1'b0;
    end

    // No queueing: a buffer write outside idle is lost
    if (bufWrite && state_reg != S_IDLE) begin
      write_collision_flag_next = 1'b1;
    end

    unique case (state_reg)
      S_IDLE: begin // Control writes decoded only here
        if (ctrlWrite && ctrlWriteData[CTRL_START]) begin
          if (sdaS && sclS) begin
            req_next[CTRL_START] = 1'b1;
            load                 = 1'b1;
            state_next           = S_ST_WAIT;
          end else begin
            bcl_next = 1'b1;
          end
        end else if (ctrlWrite && ctrlWriteData[CTRL_RESTART]) begin
          req_next[CTRL_RESTART] = 1'b1;
          sclLow_next            = 1'b1;
          state_next             = S_RS_SCLLOW;
        end else if (ctrlWrite && ctrlWriteData[CTRL_RECEIVE]) begin
          req_next[CTRL_RECEIVE] = 1'b1;
          mode_next              = IMS_MODE_RX;
          bitCnt_next            = CNT_RESET;
          sclLow_next            = 1'b1;
          sdaLow_next            = 1'b0;
          load                   = 1'b1;
          state_next             = S_BIT_LOW;
        end else if (ctrlWrite && ctrlWriteData[CTRL_ACKSEQ]) begin
          req_next[CTRL_ACKSEQ] = 1'b1;
          mode_next             = IMS_MODE_ACK;
          sclLow_next           = 1'b1;
          sdaLow_next           = !ackValueBit;
          load                  = 1'b1;
          state_next            = S_BIT_LOW;
        end else if (bufWrite) begin
          buf_next    = bufWriteData;
          shift_next  = bufWriteData;
          bf_next     = 1'b1;
          mode_next   = IMS_MODE_TX;
          bitCnt_next = CNT_RESET;
          sclLow_next = 1'b1;
          sdaLow_next = !bufWriteData[DATA_W-1];
          load        = 1'b1;
          state_next  = S_BIT_LOW;
        end
      end
      S_ST_WAIT: begin
        if (!sclS || (timeout && !sdaS)) begin
          bcl_next             = 1'b1;
          req_next[CTRL_START] = 1'b0;
          state_next           = S_IDLE;
        end else if (timeout) begin
          sdaLow_next = 1'b1;
          sdet_next   = 1'b1;
          load        = 1'b1;
          state_next  = S_ST_HOLD;
        end
      end
      S_ST_HOLD: begin
        if (timeout) begin
          req_next[CTRL_START] = 1'b0;
          pif_next             = 1'b1;
          state_next           = S_IDLE;
        end
      end
      S_RS_SCLLOW: begin
        if (!sclS) begin
          loadShort   = 1'b1;
          load        = 1'b1;
          sdaLow_next = 1'b0;
          state_next  = S_RS_SDAHI;
        end
      end
      S_RS_SDAHI: begin
        if (timeout && sdaS) begin
          sclLow_next = 1'b0;
          state_next  = S_RS_SCLREL;
        end
      end
      S_RS_SCLREL: begin
        if (sclS && !sdaS) begin
          bcl_next               = 1'b1;
          req_next[CTRL_RESTART] = 1'b0;
          state_next             = S_IDLE;
        end else if (sclS) begin
          load       = 1'b1;
          state_next = S_RS_BOTHHI;
        end
      end
      S_RS_BOTHHI: begin
        if (!sclS || !sdaS) begin
          bcl_next               = 1'b1;
          req_next[CTRL_RESTART] = 1'b0;
          state_next             = S_IDLE;
        end else if (timeout) begin
          sdaLow_next = 1'b1;
          sdet_next   = 1'b1;
          state_next  = S_RS_SDALOW;
        end
      end
      S_RS_SDALOW: begin
        if (timeout) begin
          req_next[CTRL_RESTART] = 1'b0;
          pif_next               = 1'b1;
          state_next             = S_IDLE;
        end
      end
      S_BIT_LOW: begin
        if (timeout) begin
          sclLow_next = 1'b0;
          state_next  = S_BIT_REL;
        end
      end
      S_BIT_REL: begin
        if (sclS) begin
          load       = 1'b1;
          state_next = S_BIT_HIGH;
        end
      end
      S_BIT_HIGH: begin
        if (timeout) begin
          sclLow_next = 1'b1;
          state_next  = S_BIT_LOW;
          bitCnt_next = BITCNT_W'(bitCnt_reg + 1'b1);
          unique case (mode_reg)
            IMS_MODE_TX: begin
              if (bitCnt_reg == ACK_BIT) begin
                ack_received_status_next = sdaS;
                pif_next     = 1'b1;
                byteDone     = 1'b1;
                state_next   = S_IDLE;
              end else if (bitCnt_reg == LAST_DATA_BIT) begin
                bf_next     = 1'b0;
                sdaLow_next = 1'b0;
              end else begin
                shift_next  = {shift_reg[DATA_W-2:0], 1'b0};
                sdaLow_next = !shift_reg[DATA_W-2];
              end
            end
            IMS_MODE_RX: begin
              shift_next = {shift_reg[DATA_W-2:0], sdaS};
              if (bitCnt_reg == LAST_DATA_BIT) begin
                buf_next               = {shift_reg[DATA_W-2:0], sdaS};
                bf_next                = 1'b1;
                ovf_next               = ovf_next || bf_reg;
                pif_next               = 1'b1;
                req_next[CTRL_RECEIVE] = 1'b0;
                rxDone                 = 1'b1;
                state_next             = S_IDLE;
              end
            end
            IMS_MODE_ACK: begin
              req_next[CTRL_ACKSEQ] = 1'b0;
              pif_next              = 1'b1;
              state_next            = S_IDLE;
            end
            default: begin
              state_next = S_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase

    // Bus collision frees both lines when the flag was clear
    if (bcl_next && !bcl_reg) begin
      sdaLow_next = 1'b0;
      sclLow_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= S_IDLE;
      mode_reg    <= IMS_MODE_TX;
      bitCnt_reg  <= CNT_RESET;
      shift_reg   <= DATA_RESET;
      buf_reg     <= DATA_RESET;
      req_reg     <= '0;
      sdaLow_reg  <= 1'b0;
      sclLow_reg  <= 1'b0;
      ack_received_status_reg <= 1'b0;
      bf_reg      <= 1'b0;
      write_collision_flag_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
      pif_reg     <= 1'b0;
      bcl_reg     <= 1'b0;
      sdet_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      bitCnt_reg  <= bitCnt_next;
      shift_reg   <= shift_next;
      buf_reg     <= buf_next;
      req_reg     <= req_next;
      sdaLow_reg  <= sdaLow_next;
      sclLow_reg  <= sclLow_next;
      ack_received_status_reg <= ack_received_status_next;
      bf_reg      <= bf_next;
      write_collision_flag_reg    <= write_collision_flag_next;
      ovf_reg     <= ovf_next;
      pif_reg     <= pif_next;
      bcl_reg     <= bcl_next;
      sdet_reg    <= sdet_next;
    end
  end

  // Open-drain: the output level is always low, only the enable moves
  assign sdaOut                = 1'b0;
  assign sclOut                = 1'b0;
  assign sdaOe                 = sdaLow_reg;
  assign sclOe                 = sclLow_reg;
  assign startRequestBit       = req_reg[CTRL_START];
  assign restartRequestBit     = req_reg[CTRL_RESTART];
  assign receiveRequestBit     = req_reg[CTRL_RECEIVE];
  assign ackSequenceRequestBit = req_reg[CTRL_ACKSEQ];
  assign ackReceivedStatus     = ack_received_status_reg;
  assign bufferFullFlag        = bf_reg;
  assign writeCollisionFlag    = write_collision_flag_reg;
  assign receiveOverflowFlag   = ovf_reg;
  assign portInterruptFlag     = pif_reg;
  assign busCollisionFlag      = bcl_reg;
  assign startDetected         = sdet_reg;
  assign dataBuffer            = buf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_START_ABORT: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_IDLE && ctrlWrite && ctrlWriteData[CTRL_START] && !(sdaS && sclS)
    |=> busCollisionFlag && !startRequestBit && state_reg == S_IDLE)
    else $error("start on busy lines not aborted");

  AST_START_DET: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_ST_WAIT && state_next == S_ST_HOLD |=> sdaOe && !sclOe && startDetected)
    else $error("start condition not flagged");

  AST_START_DONE: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_ST_HOLD && timeout |=> !startRequestBit && sdaOe && state_reg == S_IDLE)
    else $error("start did not complete cleanly");

  AST_WRITE_COLLISION_FLAG_BUSY: assert property (@(posedge clk) disable iff (reset)
    bufWrite && state_reg != S_IDLE
    |=> writeCollisionFlag && ($stable(dataBuffer) || $past(rxDone)))
    else $error("buffer write during activity not refused");

  AST_CTRL_BLOCK: assert property (@(posedge clk) disable iff (reset)
    ctrlWrite && state_reg inside {S_ST_WAIT, S_ST_HOLD, S_RS_SDAHI}
    |=> !$rose(receiveRequestBit) && !$rose(ackSequenceRequestBit))
    else $error("control write queued during start");

  AST_RS_SCL: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_IDLE && ctrlWrite && ctrlWriteData[CTRL_RESTART] && !ctrlWriteData[CTRL_START]
    |=> sclOe && restartRequestBit)
    else $error("restart did not pull SCL low");

  AST_TX_START: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_IDLE && bufWrite && !ctrlWrite
    |=> bufferFullFlag && sclOe && dataBuffer == $past(bufWriteData))
    else $error("buffer write did not start transmission");

  AST_ACK_STAT: assert property (@(posedge clk) disable iff (reset)
    byteDone |=> ackReceivedStatus == $past(sdaS) && portInterruptFlag && sclOe)
    else $error("acknowledge status not captured");

  AST_RD_BF: assert property (@(posedge clk) disable iff (reset)
    bufRead && !bufWrite && state_reg == S_IDLE |=> !bufferFullFlag)
    else $error("read did not clear buffer full");

  AST_OVF: assert property (@(posedge clk) disable iff (reset)
    rxDone && bufferFullFlag |=> receiveOverflowFlag && bufferFullFlag)
    else $error("overflow not flagged");

  AST_ARB_WAIT: assert property (@(posedge clk) disable iff (reset)
    state_reg == S_BIT_REL && !sclS |=> state_reg == S_BIT_REL && !sclOe)
    else $error("counter ran while SCL held low");

endmodule // ims_sequencer

// file: hw/ims_pkg.sv
// Purpose: Shared constants and types of the I2C master sequencer.
// Assumes: One 100 MHz clock; open-drain pins resolved outside.
// Notes:   Control bit positions follow the second control register layout.
package ims_pkg;

  // Second control register, lower five bits
  localparam int CTRL_LOW_W   = 5;
  localparam int CTRL_START   = 0;
  localparam int CTRL_RESTART = 1;
  localparam int CTRL_STOP    = 2;
  localparam int CTRL_RECEIVE = 3;
  localparam int CTRL_ACKSEQ  = 4;

  // Field widths
  localparam int DATA_W       = 8;
  localparam int RELOAD_W     = 7;
  localparam int RS_RELOAD_W  = 6;
  localparam int BITCNT_W     = 4;

  // Bit positions within a byte frame
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;

  // Clock cycles per rate counter decrement (two decrements per instruction cycle)
  localparam int CLKS_PER_DEC = 2;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET  = 4'h0;

  typedef enum logic [1:0] {
    IMS_MODE_TX,
    IMS_MODE_RX,
    IMS_MODE_ACK
  } ims_mode_t;

endpackage

// file: hw/ims_rate_counter.sv
// Purpose: Reload-and-count-down rate counter pacing every bus phase except the waits on pin levels.
// Assumes: load and run come from the sequencer on the same clock.
// Notes:   Auto-reloads at each timeout; holds its count while run is low.
`timescale 1ns/1ps
module ims_rate_counter
  import ims_pkg::*;
#(
  parameter int RW  = RELOAD_W,
  parameter int DIV = CLKS_PER_DEC
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Control
  input  wire logic          load,
  input  wire logic          run,
  input  wire logic [RW-1:0] reloadVal,
  // Event
  output logic               timeout
);

  generate
    if (DIV < 1 || DIV > 256 || RW < 1) begin : g_bad
      $error("ims_rate_counter: DIV must be 1 to 256 and RW at least one");
    end
  endgenerate

  logic [RW-1:0] count_reg;
  logic [RW-1:0] count_next;
  logic [7:0]    div_reg;
  logic [7:0]    div_next;
  logic          tick;

  assign tick    = (div_reg == 8'(DIV - 1));
  assign timeout = run && tick && (count_reg == '0);

  always_comb begin
    count_next = count_reg;
    div_next   = div_reg;
    if (load) begin
      count_next = reloadVal;
      div_next   = 8'h00;
    end else if (run) begin
      div_next = tick ? 8'h00 : 8'(div_reg + 8'h01);
      if (tick) begin
        count_next = (count_reg == '0) ? reloadVal : RW'(count_reg - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
      div_reg   <= 8'h00;
    end else begin
      count_reg <= count_next;
      div_reg   <= div_next;
    end
  end

endmodule // ims_rate_counter

// file: dv/ims_slave_model.sv
// Purpose: Behavioural I2C slave on the far side of the bus.
// Assumes: Bus levels are already resolved with pull-ups.
// Notes:   sync restarts the bit count before each byte.
`timescale 1ns/1ps
module ims_slave_model (
  // Bus
  input  wire logic       sclBus,
  input  wire logic       sdaBus,
  output logic            sdaOe,
  // Behaviour
  input  wire logic       sync,
  input  wire logic       ack_sequence_request_bit,
  input  wire logic       rxMode,
  input  wire logic [7:0] txByte,
  output logic [7:0]      gotByte
);
  int cnt = 0;
  int idx;
  // One process owns the bit count
  always @(posedge sclBus or posedge sync) begin
    if (sync) cnt <= 0;
    else begin
      if (cnt < 8) gotByte <= {gotByte[6:0], sdaBus};
      cnt <= cnt + 1;
    end
  end
  // Bit index only moves while SCL is low
  assign idx = sclBus ? cnt - 1 : cnt;
  assign sdaOe = rxMode ? (idx >= 0 && idx < 8 && !txByte[7-idx])
                        : (ack_sequence_request_bit && idx == 8);
endmodule // ims_slave_model

// file: dv/tb_i2c_master_sequencer.sv
// Purpose: Self-checking bench of the I2C master sequencer.
// Assumes: DIV 2 and reload 1 give 40 ns counted phases and a 110 ns SCL period.
// Notes:   STOP and clock stretching are not exercised.
`timescale 1ns/1ps
module tb_i2c_master_sequencer;
  import ims_pkg::*;
  logic clk = 0, reset = 1, ctrlWrite = 0, bufWrite = 0, bufRead = 0, ackValueBit = 0;
  logic [4:0] ctrlWriteData = 0, clrs = 0;
  logic [7:0] bufWriteData = 0, txByte = 0, gotByte, b;
  logic sync = 0, ack_sequence_request_bit = 0, rxMode = 0, jamScl = 0, slaveOe;
  logic startRequestBit, restartRequestBit, receiveRequestBit, ackSequenceRequestBit;
  logic ackReceivedStatus, bufferFullFlag, writeCollisionFlag, receiveOverflowFlag;
  logic portInterruptFlag, busCollisionFlag, startDetected, sdaOe, sclOe, sdaOutLvl, sclOutLvl;
  logic [7:0] dataBuffer, q[$];
  int n_errors = 0, checked = 0;
  wire sdaBus = !(sdaOe | slaveOe);
  wire sclBus = !(sclOe | jamScl);
  always #5 clk = ~clk;
  ims_sequencer #(.DIV(2)) u_dut (.clk(clk), .reset(reset), .ctrlWrite(ctrlWrite),
    .ctrlWriteData(ctrlWriteData), .ackValueBit(ackValueBit), .rateReloadField(7'h01),
    .bufWrite(bufWrite), .bufWriteData(bufWriteData), .bufRead(bufRead),
    .clearWriteCollision(clrs[0]), .clearOverflow(clrs[1]), .clearBusCollision(clrs[2]),
    .clearPortInterrupt(clrs[3]), .clearStartDetected(clrs[4]),
    .startRequestBit(startRequestBit), .restartRequestBit(restartRequestBit),
    .receiveRequestBit(receiveRequestBit), .ackSequenceRequestBit(ackSequenceRequestBit),
    .ackReceivedStatus(ackReceivedStatus), .bufferFullFlag(bufferFullFlag),
    .writeCollisionFlag(writeCollisionFlag), .receiveOverflowFlag(receiveOverflowFlag),
    .portInterruptFlag(portInterruptFlag), .busCollisionFlag(busCollisionFlag),
    .startDetected(startDetected), .dataBuffer(dataBuffer), .sdaIn(sdaBus),
    .sdaOut(sdaOutLvl), .sdaOe(sdaOe), .sclIn(sclBus), .sclOut(sclOutLvl), .sclOe(sclOe));
  ims_slave_model u_slave (.sclBus(sclBus), .sdaBus(sdaBus), .sdaOe(slaveOe), .sync(sync),
    .ack_sequence_request_bit(ack_sequence_request_bit), .rxMode(rxMode), .txByte(txByte), .gotByte(gotByte));
  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic ctrl(input logic [4:0] d);
    @(posedge clk) begin ctrlWrite <= 1'b1; ctrlWriteData <= d; end
    @(posedge clk) ctrlWrite <= 1'b0;
  endtask
  task automatic wbuf(input logic [7:0] d);
    @(posedge clk) begin bufWrite <= 1'b1; bufWriteData <= d; end
    @(posedge clk) bufWrite <= 1'b0;
  endtask
  task automatic clr(input logic [4:0] m);
    @(posedge clk) clrs <= m;
    @(posedge clk) clrs <= 5'h00;
  endtask
  task automatic pulseSync();
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
  endtask
  // Bounded wait for completion, then acknowledge it
  task automatic waitIrq();
    int i;
    for (i = 0; i < 2000 && portInterruptFlag !== 1'b1; i++) @(negedge clk);
    if (i == 2000) begin
      n_errors++;
      finish_test();
    end else begin
      clr(5'h08);
      @(negedge clk);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0929));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Start with SCL held low by another master
    jamScl <= 1'b1;
    repeat (4) @(posedge clk);
    ctrl(5'h01);
    repeat (8) @(negedge clk);
    check(8'(busCollisionFlag), 8'h01);
    check(8'(startRequestBit), 8'h00);
    jamScl <= 1'b0;
    clr(5'h04);
    // Start with a queued write and a queued receive
    ctrl(5'h01);
    wbuf(8'hA5);
    ctrl(5'h08);
    @(negedge clk);
    check(8'(writeCollisionFlag), 8'h01);
    check(8'(receiveRequestBit), 8'h00);
    check(8'(startRequestBit), 8'h01);
    waitIrq();
    check(8'(startDetected), 8'h01);
    check({startRequestBit, sdaOe, sclOe}, 8'h02);
    check(dataBuffer, DATA_RESET);
    check({sdaOutLvl, sclOutLvl}, 8'h00);
    clr(5'h01);
    // Two bytes out: acknowledged, then refused
    for (int k = 0; k < 2; k++) begin
      ack_sequence_request_bit <= (k == 0);
      pulseSync();
      b = 8'($urandom);
      q.push_back(b);
      wbuf(b);
      @(negedge clk);
      check({bufferFullFlag, sclOe}, 8'h03);
      wbuf(~b);
      ctrl(5'h02);
      @(negedge clk);
      check(8'(restartRequestBit), 8'h00);
      waitIrq();
      check(gotByte, q.pop_front());
      check(8'(bufferFullFlag), 8'h00);
      check(8'(ackReceivedStatus), 8'(k));
      check(8'(sclOe), 8'h01);
      check(8'(writeCollisionFlag), 8'h01);
      clr(5'h01);
    end
    // Two bytes in, the second without reading the first
    rxMode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulseSync();
      b = 8'($urandom);
      txByte <= b;
      q.push_back(b);
      ctrl(5'h08);
      waitIrq();
      check({receiveRequestBit, bufferFullFlag, sclOe}, 8'h03);
      check(dataBuffer, q.pop_front());
      check(8'(receiveOverflowFlag), 8'(k));
      if (k == 0) begin
        ctrl(5'h10);
        ctrl(5'h08);
        @(negedge clk);
        check(8'(receiveRequestBit), 8'h00);
        waitIrq();
        check(8'(ackSequenceRequestBit), 8'h00);
      end
    end
    @(posedge clk) bufRead <= 1'b1;
    @(posedge clk) bufRead <= 1'b0;
    @(negedge clk);
    check(8'(bufferFullFlag), 8'h00);
    clr(5'h12);
    // Repeated start from a held-low clock
    rxMode <= 1'b0;
    pulseSync();
    ctrl(5'h02);
    @(negedge clk);
    check(8'(sclOe), 8'h01);
    waitIrq();
    check({restartRequestBit, startDetected, sdaOe}, 8'h03);
    check(8'(busCollisionFlag), 8'h00);
    finish_test();
  end
endmodule // tb_i2c_master_sequencer
